// File: hdl/ctc_pkg.sv
// ctc_pkg: constants for the tag comparator controller
// assumes a 200 MHz clock; timings taken for the fastest speed grade
package ctc_pkg;
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          ADDR_W        = 13;
  localparam int          DATA_W        = 8;
  localparam int          NUM_WORDS     = 8192;
  // device timings in ns, clear duty limit in percent
  localparam int          T_CLEAR_NS    = 65;
  localparam int          T_CLR_REC_NS  = 5;
  localparam int          T_WRITE_NS    = 30;
  localparam int          T_DATA_SU_NS  = 15;
  localparam int          T_DATA_HLD_NS = 2;
  localparam int          T_CYCLE_NS    = 35;
  localparam int          T_ACCESS_NS   = 35;
  localparam int          T_MATCH_NS    = 37;
  localparam int          T_OE_MATCH_NS = 25;
  localparam int          T_CLR_DUTY_PC = 10;
  // least times round up
  localparam int          CY_CLEAR      = (T_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CY_CLR_REC    = (T_CLR_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CY_WRITE      = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CY_DATA_HLD   = (T_DATA_HLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CY_CYCLE      = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CY_ACCESS     = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int          CY_MATCH      = (T_MATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int          CY_OE_MATCH   = (T_OE_MATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // clear at most 10 percent of the time: idle nine clear lengths after one
  localparam int          CY_CLR_GAP    = CY_CLEAR * (100 - T_CLR_DUTY_PC) / T_CLR_DUTY_PC;
  localparam int          CNT_W         = 8;
  typedef enum logic [2:0] {OP_NONE, OP_READ, OP_WRITE, OP_COMPARE, OP_CLEAR} ctc_op_e;
endpackage

// File: hdl/ctc_timer.sv
// ctc_timer: loadable down counter marking when a phase has lasted long enough
// assumes load values fit in CNT_W bits
`timescale 1ns/10ps
`default_nettype none
module ctc_timer
  import ctc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] value,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= '0;
    else if (load)
      cnt_q <= value;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  // no path from load: callers build load from done, which would loop
  assign done = (cnt_q == '0);
endmodule
`default_nettype wire

// File: hdl/ctc_host.sv
// ctc_host: controller driving an 8K x 8 cache tag comparator SRAM over its pins
// assumes device pins are synchronous to CLK and board delays are below a cycle
//
// Behaviour
// - hold clear low 65 ns, 10% duty
// - wait 5 ns after clear before write
// - write enable high while address changes
// - address and strobe at least 30 ns
// - data 15 ns before end, 2 ns after
// - write recovery at least 0 ns
// - never drive data while device drives
`timescale 1ns/10ps
`default_nettype none
module ctc_host
  import ctc_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  // user side
  input  wire logic              REQ_VALID,
  output logic                   REQ_READY,
  input  wire logic [2:0]        REQ_OP,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic [DATA_W-1:0] REQ_DATA,
  output logic                   RSP_VALID,
  output logic [DATA_W-1:0]      RSP_DATA,
  output logic                   RSP_HIT,
  // device pins
  output logic [ADDR_W-1:0]      MEM_ADDR,
  output logic                   MEM_CS_N,
  output logic                   MEM_OE_N,
  output logic                   MEM_WE_N,
  output logic                   MEM_CLEAR_N,
  input  wire logic [DATA_W-1:0] MEM_DQ_I,
  output logic [DATA_W-1:0]      MEM_DQ_O,
  output logic                   MEM_DQ_OE,
  input  wire logic              MEM_MATCH
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_WAIT,
                            ST_CLEAR, ST_RECOVER} ctc_state_e;

  ctc_state_e        state_q;
  ctc_op_e           op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              cs_n_q;
  logic              oe_n_q;
  logic              we_n_q;
  logic              clr_n_q;
  logic              dq_oe_q;
  logic              rsp_valid_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic              rsp_hit_q;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_value;
  logic              tmr_done;
  logic              gap_load;
  logic              gap_done;

  function automatic logic [CNT_W-1:0] cy(input int n);
    cy = CNT_W'(n);
  endfunction

  ctc_timer u_phase (
    .clk    (CLK),
    .arst_n (ARST_N),
    .load   (tmr_load),
    .value  (tmr_value),
    .done   (tmr_done)
  );

  // separate counter so clear duty does not stall ordinary cycles
  ctc_timer u_clr_gap (
    .clk    (CLK),
    .arst_n (ARST_N),
    .load   (gap_load),
    .value  (cy(CY_CLR_GAP)),
    .done   (gap_done)
  );

  wire logic req_op_clear = (REQ_OP == 3'(OP_CLEAR));
  wire logic accept = (state_q == ST_IDLE) && REQ_VALID && (!req_op_clear || gap_done);

  assign REQ_READY = (state_q == ST_IDLE) && (!req_op_clear || gap_done);
  // gap counted from the end of the pulse so low time stays a tenth of the period
  assign gap_load  = (state_q == ST_CLEAR) && tmr_done;

  // ==========================================================
  // sequencer
  always_comb
  begin
    tmr_load  = 1'b0;
    tmr_value = '0;
    case (state_q)
      ST_IDLE:
      begin
        tmr_load = accept;
        if (REQ_OP == 3'(OP_CLEAR))
          // one short: the accepting edge already drives clear low
          tmr_value = cy(CY_CLEAR - 1);
        else if (REQ_OP == 3'(OP_WRITE))
          tmr_value = cy(1);
        else if (REQ_OP == 3'(OP_READ))
          tmr_value = cy(CY_ACCESS);
        else
          tmr_value = cy(CY_MATCH);
      end
      ST_SETUP:
      begin
        tmr_load  = tmr_done;
        tmr_value = cy(CY_WRITE);
      end
      ST_STROBE:
      begin
        tmr_load  = tmr_done;
        tmr_value = cy(CY_DATA_HLD);
      end
      ST_HOLD:
      begin
        tmr_load  = tmr_done;
        // select low spans setup, strobe and hold, already past the cycle minimum
        tmr_value = cy((CY_CYCLE > CY_WRITE + 3) ? CY_CYCLE - CY_WRITE - 2 : 1);
      end
      ST_CLEAR:
      begin
        tmr_load  = tmr_done;
        tmr_value = cy(CY_CLR_REC);
      end
      default:
      begin
        tmr_load  = 1'b0;
        tmr_value = '0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      state_q <= ST_IDLE;
    else
      case (state_q)
        ST_IDLE:
          if (accept)
            state_q <= req_op_clear ? ST_CLEAR :
                       (REQ_OP == 3'(OP_WRITE)) ? ST_SETUP : ST_WAIT;
        ST_SETUP:   if (tmr_done) state_q <= ST_STROBE;
        ST_STROBE:  if (tmr_done) state_q <= ST_HOLD;
        ST_HOLD:    if (tmr_done) state_q <= ST_RECOVER;
        ST_WAIT:    if (tmr_done) state_q <= ST_IDLE;
        ST_CLEAR:   if (tmr_done) state_q <= ST_RECOVER;
        ST_RECOVER: if (tmr_done) state_q <= ST_IDLE;
        default:    state_q <= ST_IDLE;
      endcase
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      op_q    <= OP_NONE;
      addr_q  <= '0;
      wdata_q <= '0;
    end
    else if (accept)
    begin
      // address only moves in idle, where write enable is high
      op_q    <= ctc_op_e'(REQ_OP);
      addr_q  <= REQ_ADDR;
      wdata_q <= REQ_DATA;
    end
  end

  // ==========================================================
  // pin drive
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cs_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      clr_n_q <= 1'b1;
      dq_oe_q <= 1'b0;
    end
    else
    begin
      clr_n_q <= !(state_q == ST_IDLE ? (accept && req_op_clear)
                                      : (state_q == ST_CLEAR && !tmr_done));
      // chip select asserted with the address so late-select float never applies
      cs_n_q  <= !(state_q == ST_IDLE ? (accept && !req_op_clear)
                   : (state_q == ST_SETUP || state_q == ST_STROBE || state_q == ST_WAIT
                      || (state_q == ST_HOLD && !tmr_done)));
      oe_n_q  <= !(state_q == ST_IDLE ? (accept && REQ_OP == 3'(OP_READ))
                   : (state_q == ST_WAIT && op_q == OP_READ));
      we_n_q  <= !((state_q == ST_SETUP && tmr_done)
                   || (state_q == ST_STROBE && !tmr_done));
      // drive data in write and compare phases, oe is high there so device never drives
      dq_oe_q <= (state_q == ST_SETUP) || (state_q == ST_STROBE)
                 || (state_q == ST_WAIT && op_q != OP_READ)
                 || (state_q == ST_IDLE && accept && !req_op_clear
                     && REQ_OP != 3'(OP_READ));
    end
  end

  assign MEM_ADDR    = addr_q;
  assign MEM_CS_N    = cs_n_q;
  assign MEM_OE_N    = oe_n_q;
  assign MEM_WE_N    = we_n_q;
  assign MEM_CLEAR_N = clr_n_q;
  assign MEM_DQ_O    = wdata_q;
  assign MEM_DQ_OE   = dq_oe_q;

  // ==========================================================
  // response capture at end of wait, after access or compare time
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
      rsp_hit_q   <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= (state_q == ST_WAIT) && tmr_done;
      if ((state_q == ST_WAIT) && tmr_done)
      begin
        rsp_data_q <= (op_q == OP_READ) ? MEM_DQ_I : wdata_q;
        // released open-drain line reads high: match; unused codes act as compare
        rsp_hit_q  <= (op_q != OP_READ) && MEM_MATCH;
      end
    end
  end

  assign RSP_VALID = rsp_valid_q;
  assign RSP_DATA  = rsp_data_q;
  assign RSP_HIT   = rsp_hit_q;
endmodule
`default_nettype wire

// File: verification/ctc_tag_sram.sv
// ctc_tag_sram: behavioural tag comparator sram facing ctc_host
// assumes pins move just after CLK edges; bench resolves dq and pulls match up
`timescale 1ns/10ps
`default_nettype none
module ctc_tag_sram
  import ctc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              clear_n,
  input  wire logic              cs_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   match_pd
);
  logic [DATA_W-1:0] mem_q [NUM_WORDS];
  logic [DATA_W-1:0] last_q = '0;
  logic              drive;
  always_ff @(posedge clk)
    if (!clear_n)
      foreach (mem_q[i]) mem_q[i] <= '0;
    else if (!cs_n && !we_n)
      mem_q[addr] <= dq_i;
  // never drives while write enable is low, whatever order select came in
  assign drive    = clear_n && !cs_n && !oe_n && we_n;
  always_ff @(posedge clk)
    last_q <= dq_o;
  // released lines toggle so a stale sample cannot pass
  assign dq_o     = drive ? mem_q[addr] : ~last_q;
  assign match_pd = clear_n && !cs_n && oe_n && we_n && (mem_q[addr] != dq_i);
endmodule
`default_nettype wire

// File: verification/ctc_host_properties.sv
// ctc_host_properties: pin ordering checks on the device side of ctc_host
// assumes bound into ctc_host; all pins sampled on CLK
`timescale 1ns/10ps
`default_nettype none
module ctc_host_properties
  import ctc_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  input  wire logic [ADDR_W-1:0] MEM_ADDR,
  input  wire logic              MEM_CS_N,
  input  wire logic              MEM_OE_N,
  input  wire logic              MEM_WE_N,
  input  wire logic              MEM_CLEAR_N,
  input  wire logic [DATA_W-1:0] MEM_DQ_O,
  input  wire logic              MEM_DQ_OE
);
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic [7:0] gap_q;
  logic       cs_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // =====================
  // run lengths; high and gap counts saturate so a long idle never wraps
  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      lo_q  <= 8'h00;
      hi_q  <= 8'hff;
      gap_q <= 8'hff;
      cs_q  <= 1'b1;
    end
    else
    begin
      lo_q  <= MEM_CLEAR_N ? 8'h00 : lo_q + 8'h01;
      hi_q  <= !MEM_CLEAR_N ? 8'h00 : hi_q + {7'h00, hi_q != 8'hff};
      gap_q <= (cs_q && !MEM_CS_N) ? 8'h01 : gap_q + {7'h00, gap_q != 8'hff};
      cs_q  <= MEM_CS_N;
    end
  sequence write_held_s;
    !MEM_WE_N && !MEM_CS_N && MEM_DQ_OE && $stable(MEM_ADDR) && $stable(MEM_DQ_O);
  endsequence
  sequence data_held_s;
    MEM_DQ_OE && $stable(MEM_DQ_O);
  endsequence
  // =====================
  clear_len_a: assert property ($rose(MEM_CLEAR_N) |-> lo_q >= CY_CLEAR)
    else $error("clear pulse too short");
  clear_gap_a: assert property ($fell(MEM_CLEAR_N) |-> hi_q >= CY_CLR_GAP)
    else $error("clear duty too high");
  clear_rec_a: assert property ($rose(MEM_CLEAR_N) |-> MEM_WE_N ##1 MEM_WE_N)
    else $error("write strobe too soon after clear");
  strobe_len_a: assert property ($fell(MEM_WE_N) |-> write_held_s [*6])
    else $error("write strobe short or unstable");
  write_end_a: assert property ($rose(MEM_WE_N) |-> !MEM_CS_N && $stable(MEM_ADDR))
    else $error("select or address moved at write end");
  data_hold_a: assert property ($rose(MEM_WE_N) |-> data_held_s ##1 $stable(MEM_ADDR))
    else $error("write data not held");
  bus_free_a: assert property (MEM_DQ_OE |-> MEM_OE_N || MEM_CS_N || !MEM_WE_N)
    else $error("host drives data while device drives");
  cycle_gap_a: assert property ($fell(MEM_CS_N) |-> gap_q >= CY_CYCLE)
    else $error("cycles too close");
endmodule
bind ctc_host ctc_host_properties ctc_host_properties_i (
  .CLK(CLK), .ARST_N(ARST_N), .MEM_ADDR(MEM_ADDR), .MEM_CS_N(MEM_CS_N),
  .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N), .MEM_CLEAR_N(MEM_CLEAR_N),
  .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE)
);
`default_nettype wire

// File: verification/tb_ctc_host.sv
// tb_ctc_host: self-checking bench, ctc_host against a behavioural tag sram
// assumes ctc_pkg, ctc_host and the sram model compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_ctc_host
  import ctc_pkg::*;
;
  typedef struct packed {logic rd; logic [DATA_W:0] v;} ctc_exp_s;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              req_valid = 1'b0;
  logic [2:0]        req_op = 3'h0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_data = '0;
  logic              req_ready, rsp_valid, rsp_hit, cs_n, oe_n, we_n, clear_n, dq_oe, match_pd;
  logic [DATA_W-1:0] rsp_data, dq_o, dq_dev, dq_bus;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       rng = 32'hd16c_f8e8;
  logic [DATA_W-1:0] shadow [int];
  ctc_exp_s          exp_q [$];
  ctc_exp_s          e;
  int                num_errors = 0;
  int                checked = 0;
  int                cycles = 0;
  assign dq_bus = dq_oe ? dq_o : dq_dev;
  ctc_host ctc_host_i (
    .CLK(clk), .ARST_N(arst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .RSP_HIT(rsp_hit), .MEM_ADDR(addr), .MEM_CS_N(cs_n),
    .MEM_OE_N(oe_n), .MEM_WE_N(we_n), .MEM_CLEAR_N(clear_n), .MEM_DQ_I(dq_bus),
    .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe), .MEM_MATCH(~match_pd)
  );
  ctc_tag_sram ctc_tag_sram_i (
    .clk(clk), .clear_n(clear_n), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .dq_i(dq_bus), .dq_o(dq_dev), .match_pd(match_pd)
  );
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // =====================
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic check(input logic [DATA_W:0] seen, input logic [DATA_W:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // entered 1 ns after an edge; holds the request until taken
  task automatic send(input logic [2:0] op, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] cur;
    cur       = shadow.exists(a) ? shadow[a] : 8'h00;
    req_valid = 1'b1;
    req_op    = op;
    req_addr  = a;
    req_data  = d;
    while (req_ready !== 1'b1)
      @(posedge clk) #1;
    @(posedge clk) #1;
    req_valid = 1'b0;
    if (op == 3'h1)
      exp_q.push_back({1'b1, cur, 1'b0});
    else if (op == 3'h2)
      shadow[a] = d;
    else if (op == 3'h4)
      shadow.delete();
    else
      exp_q.push_back({1'b0, d, cur === d});
    // one edge between requests so valid never drops and rises in one step
    @(posedge clk) #1;
  endtask
  // =====================
  // mid-cycle sampling keeps clear of the edge that launches the response
  always @(negedge clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check({rsp_data, rsp_hit}, 'x);
      else
      begin
        e = exp_q.pop_front();
        if (e.rd)
          check({rsp_data, 1'b0}, e.v);
        else
          check({rsp_data, rsp_hit}, e.v);
      end
    end
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    logic [31:0]       r;
    logic [ADDR_W-1:0] a;
    logic [2:0]        op;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    send(3'h4, '0, '0);
    repeat (20) @(posedge clk);
    #1;
    check({8'h00, req_ready}, 9'h000);
    send(3'h4, '0, '0);
    send(3'h1, 13'h1fff, '0);
    send(3'h3, 13'h0000, 8'h00);
    // few addresses at both ends so writes, hits and misses meet
    for (int i = 0; i < 48; i++)
    begin
      r  = xs();
      a  = {{11{r[3]}}, r[2:1]};
      op = (r[6:4] > 3'h4) ? 3'h3 : r[6:4];
      send(op, a, (r[7] && shadow.exists(a)) ? shadow[a] : r[15:8]);
    end
    while (exp_q.size() != 0)
      @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
